// ---- rtl/selector_pkg.sv ----
/*
 Constants and carriers for the position selector.
 Assumes a 200 MHz system clock and milliseconds as the timer base.
*/
package selector_pkg;
   localparam int CLK_HZ = 200000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int ALARM_HOLD_MS = 3000;
   localparam int STEP_SPACING_MS = 50;
   localparam logic [15:0] ALARM_HOLD_TICKS = 16'(ALARM_HOLD_MS / TICK_MS);
   localparam logic [2:0] REST_CODE = 3'h0;
   localparam logic [2:0] MAX_POSITION = 3'h7;
   localparam logic [2:0] POS_RESET = 3'h0;

   typedef enum logic {APPLY_TIMEOUT, APPLY_CONFIRM} apply_mode_t;
   typedef enum logic {START_RESTORE, START_FOLLOW} startup_mode_t;

   typedef struct packed {
      logic [2:0] upper_limit;
      apply_mode_t increment_apply_mode;
      apply_mode_t coded_apply_mode;
      startup_mode_t startup_mode;
      logic [15:0] timeout_ms;
      logic [15:0] notice_ms;
      logic events_enable;
   } config_t;

   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [2:0] position;
   } event_t;

   localparam logic [1:0] EV_POSITION = 2'h0;
   localparam logic [1:0] EV_INC_ALARM = 2'h1;
   localparam logic [1:0] EV_CODED_ALARM = 2'h2;
endpackage : selector_pkg

// ---- rtl/ms_timer.sv ----
/*
 Millisecond down-counter, loaded with a count, fires once at zero.
 Assumes a shared one-cycle tick enable from the top module.
*/
`timescale 1ns/100ps
module ms_timer (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic tick_i,
   input wire logic load_i,
   input wire logic [15:0] count_i,
   input wire logic stop_i,
   output logic running_o,
   output logic expired_o
);
   logic [15:0] count_q;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         count_q <= 16'h0000;
         running_o <= 1'b0;
         expired_o <= 1'b0;
      end else begin
         expired_o <= 1'b0;
         if (load_i) begin
            count_q <= count_i;
            running_o <= 1'b1;
         end else if (stop_i) begin
            running_o <= 1'b0;
         end else if (running_o && tick_i) begin
            if (count_q <= 16'h0001) begin
               running_o <= 1'b0;
               expired_o <= 1'b1;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end
endmodule : ms_timer

// ---- rtl/position_selector_switch.sv ----
/*
 Position selector: increment and coded pre-selection, time-out or confirm
 apply, alarms, start-up policy and event pulses.
 Assumes pin inputs are asynchronous and the stored position is stable at reset.
*/
// Functional notes
// - Increment time-out mode applies pending position after input inactivity time-out.
// - Activity restarts timer; confirm mode expiry discards change and alarms.
// - Each increment rising edge outside a coded sequence advances pending position, wrapping after limit.
// - Increment edge restarts timer and shows change notice with pending position.
// - Increment confirm expiry rejects change, increment alarm for 3 seconds.
// - Increment confirm edge applies only in confirm mode, ignored otherwise.
// - Coded word 1..7 pre-selects positions 1..7; zero is rest.
// - Rest code causes no action.
// - Coded time-out mode applies after time-out since last coded change.
// - Coded confirm edge applies pending coded position within time-out.
// - Increment and coded sequences lock each other out.
// - Coded confirm expiry rejects change, coded alarm for 3 seconds.
// - Each confirm input acts only on its own path.
// - Restore policy reloads stored position after power-up.
// - Follow policy takes coded word at power-up without waiting.
// - Follow policy rest or out-of-range word gives position zero and alarm.
// - Restored out-of-range position gives position zero and alarm.
// - With logging enabled, pulse events on apply and confirm time-outs.
// - Applied position shown as 3-bit coded word.
// - Coded word above limit raises range alarm 3 s, keeps position.
// - Upper limit is highest position; stepping wraps to one.
`timescale 1ns/100ps
module position_selector_switch
   import selector_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire config_t CFG_I,
   input wire logic [2:0] STORED_POSITION_I,
   input wire logic INCREMENT_I,
   input wire logic INCREMENT_CONFIRM_I,
   input wire logic [2:0] CODED_SELECT_I,
   input wire logic CODED_CONFIRM_I,
   output logic [2:0] POSITION_CODE_O,
   output logic [7:1] POSITION_ONEHOT_O,
   output logic [2:0] PENDING_POSITION_O,
   output logic CHANGE_NOTICE_O,
   output logic INCREMENT_CONFIRM_ALARM_O,
   output logic CODED_CONFIRM_ALARM_O,
   output logic RANGE_ALARM_O,
   output logic STARTUP_ALARM_O,
   output logic STORE_POSITION_O,
   output event_t EVENT_O
);
   typedef enum logic [1:0] {ST_START, ST_IDLE, ST_INC, ST_CODED} state_t;

   state_t state_q;
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] prev_q;
   logic [2:0] pos_q;
   logic [2:0] pend_q;
   logic [17:0] tick_cnt_q;
   logic tick;
   logic inc_rise;
   logic inc_ack_rise;
   logic code_ack_rise;
   logic code_change;
   logic [2:0] code;
   logic code_in_range;
   logic seq_load;
   logic seq_stop;
   logic seq_running;
   logic seq_expired;
   logic notice_load;
   logic notice_running;
   logic inc_alarm_set;
   logic code_alarm_set;
   logic range_alarm_set;
   logic apply_now;
   logic [2:0] apply_pos;
   logic [2:0] al_load;
   logic [2:0] al_running;

   // Two-flop synchronisers; edges taken only from the second stage
   // No reset: the chain keeps sampling through reset, so the start-up
   // cycle sees the coded word held across release
   // Edges seen in the start-up cycle are dropped by the state machine
   always_ff @(posedge CLK_I) begin
      sync1_q <= {INCREMENT_I, INCREMENT_CONFIRM_I, CODED_CONFIRM_I, CODED_SELECT_I};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
   end

   assign code = sync2_q[2:0];
   assign inc_rise = sync2_q[5] & ~prev_q[5];
   assign inc_ack_rise = sync2_q[4] & ~prev_q[4];
   assign code_ack_rise = sync2_q[3] & ~prev_q[3];
   // Rest code never counts as activity, so a faulty source stays quiet
   assign code_change = (code != prev_q[2:0]) && (code != REST_CODE);
   assign code_in_range = (code != REST_CODE) && (code <= CFG_I.upper_limit);

   // Millisecond tick shared by all timers
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         tick_cnt_q <= 18'h00000;
      end else if (tick_cnt_q == 18'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= 18'h00000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 18'h00001;
      end
   end
   assign tick = (tick_cnt_q == 18'(TICK_CYCLES - 1));

   // Sequence control
   always_comb begin
      seq_load = 1'b0;
      seq_stop = 1'b0;
      apply_now = 1'b0;
      apply_pos = pend_q;
      notice_load = 1'b0;
      inc_alarm_set = 1'b0;
      code_alarm_set = 1'b0;
      range_alarm_set = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (inc_rise) begin
               seq_load = 1'b1;
               notice_load = 1'b1;
            end else if (code_change) begin
               if (code_in_range) begin
                  seq_load = 1'b1;
               end else begin
                  range_alarm_set = 1'b1;
               end
            end
         end
         ST_INC: begin
            // Coded inputs are ignored here
            if (inc_rise) begin
               seq_load = 1'b1;
               notice_load = 1'b1;
            end else if (CFG_I.increment_apply_mode == APPLY_CONFIRM && inc_ack_rise) begin
               seq_stop = 1'b1;
               apply_now = 1'b1;
            end else if (seq_expired) begin
               if (CFG_I.increment_apply_mode == APPLY_TIMEOUT) begin
                  apply_now = 1'b1;
               end else begin
                  inc_alarm_set = 1'b1;
               end
            end
         end
         ST_CODED: begin
            // Increment input is ignored here
            if (code_change) begin
               if (code_in_range) begin
                  seq_load = 1'b1;
               end else begin
                  range_alarm_set = 1'b1;
               end
            end else if (CFG_I.coded_apply_mode == APPLY_CONFIRM && code_ack_rise) begin
               seq_stop = 1'b1;
               apply_now = 1'b1;
            end else if (seq_expired) begin
               if (CFG_I.coded_apply_mode == APPLY_TIMEOUT) begin
                  apply_now = 1'b1;
               end else begin
                  code_alarm_set = 1'b1;
               end
            end
         end
         default: begin
            apply_now = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state_q <= ST_START;
      end else begin
         case (state_q)
            ST_START: state_q <= ST_IDLE;
            ST_IDLE: begin
               if (inc_rise) begin
                  state_q <= ST_INC;
               end else if (code_change && code_in_range) begin
                  state_q <= ST_CODED;
               end
            end
            ST_INC: begin
               if (apply_now || inc_alarm_set) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_CODED: begin
               if (!seq_load && (apply_now || code_alarm_set)) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Pending position
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         pend_q <= POS_RESET;
      end else if (state_q == ST_START) begin
         pend_q <= POS_RESET;
      end else if (inc_rise && (state_q == ST_IDLE || state_q == ST_INC)) begin
         if (state_q == ST_IDLE) begin
            pend_q <= (pos_q >= CFG_I.upper_limit) ? 3'h1 : pos_q + 3'h1;
         end else begin
            pend_q <= (pend_q >= CFG_I.upper_limit) ? 3'h1 : pend_q + 3'h1;
         end
      end else if (seq_load && state_q != ST_INC) begin
         pend_q <= code;
      end
   end

   // Applied position and start-up policy
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         pos_q <= POS_RESET;
         STARTUP_ALARM_O <= 1'b0;
         STORE_POSITION_O <= 1'b0;
      end else begin
         STORE_POSITION_O <= 1'b0;
         if (state_q == ST_START) begin
            // Synchronisers are loaded by now, so the coded word is valid
            if (CFG_I.startup_mode == START_FOLLOW) begin
               if (code_in_range) begin
                  pos_q <= code;
               end else begin
                  pos_q <= POS_RESET;
                  STARTUP_ALARM_O <= 1'b1;
               end
            end else if (STORED_POSITION_I != REST_CODE &&
                         STORED_POSITION_I <= CFG_I.upper_limit) begin
               pos_q <= STORED_POSITION_I;
            end else begin
               pos_q <= POS_RESET;
               STARTUP_ALARM_O <= 1'b1;
            end
         end else if (apply_now) begin
            pos_q <= apply_pos;
            STORE_POSITION_O <= 1'b1;
            STARTUP_ALARM_O <= 1'b0;
         end
      end
   end

   // Event pulses
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         EVENT_O <= '0;
      end else begin
         EVENT_O <= '0;
         if (CFG_I.events_enable) begin
            if (apply_now) begin
               EVENT_O <= '{valid: 1'b1, kind: EV_POSITION, position: apply_pos};
            end else if (inc_alarm_set) begin
               EVENT_O <= '{valid: 1'b1, kind: EV_INC_ALARM, position: pend_q};
            end else if (code_alarm_set) begin
               EVENT_O <= '{valid: 1'b1, kind: EV_CODED_ALARM, position: pend_q};
            end
         end
      end
   end

   // Registered outputs
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         POSITION_CODE_O <= 3'h0;
         POSITION_ONEHOT_O <= 7'h00;
         PENDING_POSITION_O <= 3'h0;
         CHANGE_NOTICE_O <= 1'b0;
         INCREMENT_CONFIRM_ALARM_O <= 1'b0;
         CODED_CONFIRM_ALARM_O <= 1'b0;
         RANGE_ALARM_O <= 1'b0;
      end else begin
         POSITION_CODE_O <= pos_q;
         for (int i = 1; i <= 7; i++) begin
            POSITION_ONEHOT_O[i] <= (pos_q == 3'(i));
         end
         PENDING_POSITION_O <= pend_q;
         CHANGE_NOTICE_O <= notice_running;
         INCREMENT_CONFIRM_ALARM_O <= al_running[0];
         CODED_CONFIRM_ALARM_O <= al_running[1];
         RANGE_ALARM_O <= al_running[2];
      end
   end

   assign al_load = {range_alarm_set, code_alarm_set, inc_alarm_set};

   // Timers: sequence time-out, notice, and three alarm holds
   ms_timer u_seq_timer (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .tick_i(tick),
      .load_i(seq_load),
      .count_i(CFG_I.timeout_ms),
      .stop_i(seq_stop),
      .running_o(seq_running),
      .expired_o(seq_expired)
   );

   ms_timer u_notice_timer (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .tick_i(tick),
      .load_i(notice_load),
      .count_i(CFG_I.notice_ms),
      .stop_i(1'b0),
      .running_o(notice_running),
      .expired_o()
   );

   generate
      for (genvar g = 0; g < 3; g++) begin : g_alarm
         ms_timer u_alarm_timer (
            .clk_i(CLK_I),
            .reset_n_i(RESET_N_I),
            .tick_i(tick),
            .load_i(al_load[g]),
            .count_i(ALARM_HOLD_TICKS),
            .stop_i(1'b0),
            .running_o(al_running[g]),
            .expired_o()
         );
      end
   endgenerate
endmodule : position_selector_switch

// ---- test/selector_checker_asserts.sv ----
/*
 Checker for the position selector, bound to its top module.
 Assumes static configuration and a stable start-up word around reset release.
*/
`timescale 1ns/100ps
module selector_checker
   import selector_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire config_t CFG_I,
   input wire logic [2:0] STORED_POSITION_I,
   input wire logic [2:0] CODED_SELECT_I,
   input wire logic [2:0] POSITION_CODE_O,
   input wire logic [7:1] POSITION_ONEHOT_O,
   input wire logic [2:0] PENDING_POSITION_O,
   input wire logic CHANGE_NOTICE_O,
   input wire logic INCREMENT_CONFIRM_ALARM_O,
   input wire logic CODED_CONFIRM_ALARM_O,
   input wire logic RANGE_ALARM_O,
   input wire logic STARTUP_ALARM_O,
   input wire logic STORE_POSITION_O,
   input wire event_t EVENT_O
);
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   logic [2:0] up_q;
   logic [2:0] boot_pos;
   logic boot_ok;
   // Start-up load is no apply, so skip the first cycles
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   assign boot_pos = (CFG_I.startup_mode == START_RESTORE) ? STORED_POSITION_I
      : CODED_SELECT_I;
   assign boot_ok = (boot_pos != 3'h0) && (boot_pos <= CFG_I.upper_limit);
   property p_startup;
      $rose(RESET_N_I) |-> ##[1:3] POSITION_CODE_O == (boot_ok ? boot_pos : 3'h0)
         && STARTUP_ALARM_O == !boot_ok;
   endproperty
   a_startup: assert property (p_startup)
      else $error("start-up position wrong");
   property p_onehot;
      POSITION_ONEHOT_O == ((POSITION_CODE_O == 3'h0) ? 7'h00
         : 7'(7'h01 << (POSITION_CODE_O - 3'h1)));
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("one-hot output disagrees with code");
   property p_store;
      up_q == 3'h7 && $changed(POSITION_CODE_O) |-> $past(STORE_POSITION_O);
   endproperty
   a_store: assert property (p_store)
      else $error("position changed without store");
   property p_event;
      STORE_POSITION_O && CFG_I.events_enable |-> EVENT_O.valid
         && EVENT_O.kind == EV_POSITION ##1 POSITION_CODE_O == $past(EVENT_O.position);
   endproperty
   a_event: assert property (p_event)
      else $error("apply without position event");
   property p_range;
      $rose(RANGE_ALARM_O) |-> $stable(POSITION_CODE_O) ##1 RANGE_ALARM_O[*8];
   endproperty
   a_range: assert property (p_range)
      else $error("range alarm short or moved position");
   property p_inc_alarm;
      $rose(INCREMENT_CONFIRM_ALARM_O) |-> CFG_I.increment_apply_mode == APPLY_CONFIRM
         && !STORE_POSITION_O ##1 INCREMENT_CONFIRM_ALARM_O[*8];
   endproperty
   a_inc_alarm: assert property (p_inc_alarm)
      else $error("increment alarm wrong");
   property p_cod_alarm;
      $rose(CODED_CONFIRM_ALARM_O) |-> CFG_I.coded_apply_mode == APPLY_CONFIRM
         && !STORE_POSITION_O ##1 CODED_CONFIRM_ALARM_O[*8];
   endproperty
   a_cod_alarm: assert property (p_cod_alarm)
      else $error("coded alarm wrong");
   property p_notice;
      $rose(CHANGE_NOTICE_O) |-> PENDING_POSITION_O != 3'h0
         && PENDING_POSITION_O <= CFG_I.upper_limit ##1 CHANGE_NOTICE_O[*8];
   endproperty
   a_notice: assert property (p_notice)
      else $error("notice or pending wrong");
   c_store: cover property (STORE_POSITION_O);
   c_range: cover property ($rose(RANGE_ALARM_O));
   c_notice: cover property ($rose(CHANGE_NOTICE_O));
endmodule : selector_checker

bind position_selector_switch selector_checker i_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
   .CFG_I(CFG_I), .STORED_POSITION_I(STORED_POSITION_I), .CODED_SELECT_I(CODED_SELECT_I),
   .POSITION_CODE_O(POSITION_CODE_O), .POSITION_ONEHOT_O(POSITION_ONEHOT_O),
   .PENDING_POSITION_O(PENDING_POSITION_O), .CHANGE_NOTICE_O(CHANGE_NOTICE_O),
   .INCREMENT_CONFIRM_ALARM_O(INCREMENT_CONFIRM_ALARM_O),
   .CODED_CONFIRM_ALARM_O(CODED_CONFIRM_ALARM_O), .RANGE_ALARM_O(RANGE_ALARM_O),
   .STARTUP_ALARM_O(STARTUP_ALARM_O), .STORE_POSITION_O(STORE_POSITION_O),
   .EVENT_O(EVENT_O));

// ---- test/operand_source.sv ----
/*
 Operand source: pushbuttons and coded contacts driving the selector.
 Assumes the bench calls its tasks and that reset means a fresh power-up.
*/
`timescale 1ns/100ps
module operand_source
   import selector_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   output logic increment_o,
   output logic increment_confirm_o,
   output logic [2:0] coded_select_o,
   output logic coded_confirm_o
);
   localparam int SPACING = STEP_SPACING_MS * TICK_CYCLES;
   int gap_q;
   initial begin
      increment_o = 1'b0;
      increment_confirm_o = 1'b0;
      coded_select_o = 3'h0;
      coded_confirm_o = 1'b0;
   end
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         gap_q <= SPACING;
      end else if (increment_o) begin
         gap_q <= 0;
      end else if (gap_q < SPACING) begin
         gap_q <= gap_q + 1;
      end
   end
   // Waits out the spacing instead of stepping too fast
   task automatic pulse(input int sel);
      while (sel == 0 && gap_q < SPACING) @(posedge clk_i);
      @(posedge clk_i);
      increment_o <= (sel == 0);
      increment_confirm_o <= (sel == 1);
      coded_confirm_o <= (sel == 2);
      repeat (4) @(posedge clk_i);
      increment_o <= 1'b0;
      increment_confirm_o <= 1'b0;
      coded_confirm_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1;
   endtask : pulse
   task automatic set_code(input logic [2:0] c);
      @(posedge clk_i);
      coded_select_o <= c;
      repeat (6) @(posedge clk_i);
      #1;
   endtask : set_code
endmodule : operand_source

// ---- test/position_selector_switch_test.sv ----
/*
 Self-checking bench for the position selector.
 Assumes the operand source model drives all pushbutton and coded inputs.
*/
`timescale 1ns/100ps
module position_selector_switch_test
   import selector_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   config_t cfg = '0;
   logic [2:0] stored = 3'h0;
   logic inc, inc_cf, code_cf, notice, inc_al, cod_al, rng_al, st_al, store;
   logic [2:0] code, pos, pend, e;
   logic [7:1] hot;
   event_t ev, ev_last;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int store_cnt = 0;
   logic ev_en = 1'b1;
   logic [15:0] tmo = 16'h0005;
   logic [2:0] fc [3] = '{3'h3, 3'h0, 3'h6};
   always #2.5 clk = ~clk;
   operand_source i_src (.clk_i(clk), .reset_n_i(rst_n), .increment_o(inc),
      .increment_confirm_o(inc_cf), .coded_select_o(code), .coded_confirm_o(code_cf));
   position_selector_switch i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CFG_I(cfg),
      .STORED_POSITION_I(stored), .INCREMENT_I(inc), .INCREMENT_CONFIRM_I(inc_cf),
      .CODED_SELECT_I(code), .CODED_CONFIRM_I(code_cf), .POSITION_CODE_O(pos),
      .POSITION_ONEHOT_O(hot), .PENDING_POSITION_O(pend), .CHANGE_NOTICE_O(notice),
      .INCREMENT_CONFIRM_ALARM_O(inc_al), .CODED_CONFIRM_ALARM_O(cod_al),
      .RANGE_ALARM_O(rng_al), .STARTUP_ALARM_O(st_al), .STORE_POSITION_O(store),
      .EVENT_O(ev));
   task automatic final_report();
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Pulses last one cycle, so catch them as they pass
   always @(posedge clk) begin
      cyc++;
      if (store) store_cnt++;
      if (ev.valid) ev_last = ev;
      if (cyc == 5000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Timeouts of 5 ms and 7 ms stay far beyond every check window
   task automatic boot(input logic [2:0] lim, input apply_mode_t im, input apply_mode_t cm,
         input startup_mode_t sm, input logic [2:0] sp, input logic [2:0] cd);
      @(posedge clk);
      rst_n <= 1'b0;
      cfg <= '{lim, im, cm, sm, tmo, tmo + 16'h0001, ev_en};
      stored <= sp;
      i_src.set_code(cd);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      store_cnt = 0;
      ev_last = '0;
   endtask : boot
   initial begin
      boot(3'h7, APPLY_TIMEOUT, APPLY_TIMEOUT, START_RESTORE, 3'h5, 3'h0);
      check(pos, 3'h5);
      check(hot, 7'h10);
      check(st_al, 1'b0);
      boot(3'h4, APPLY_TIMEOUT, APPLY_TIMEOUT, START_RESTORE, 3'h6, 3'h0);
      check(pos, 3'h0);
      check(hot, 7'h00);
      check(st_al, 1'b1);
      for (int k = 0; k < 3; k++) begin
         boot(3'h5, APPLY_TIMEOUT, APPLY_TIMEOUT, START_FOLLOW, 3'h0, fc[k]);
         e = (fc[k] inside {[3'h1:3'h5]}) ? fc[k] : 3'h0;
         check(pos, e);
         check(st_al, e == 3'h0);
      end
      boot(3'h4, APPLY_CONFIRM, APPLY_TIMEOUT, START_RESTORE, 3'h4, 3'h0);
      i_src.pulse(0);
      check(pend, 3'h1);
      check(notice, 1'b1);
      check(pos, 3'h4);
      i_src.set_code(3'h2);
      check(pend, 3'h1);
      i_src.pulse(2);
      check(pos, 3'h4);
      i_src.pulse(1);
      check(pos, 3'h1);
      check(hot, 7'h01);
      check(store_cnt, 1);
      check(ev_last, {1'b1, EV_POSITION, 3'h1});
      boot(3'h7, APPLY_TIMEOUT, APPLY_TIMEOUT, START_RESTORE, 3'h2, 3'h0);
      i_src.pulse(0);
      check(pend, 3'h3);
      i_src.pulse(1);
      check(pos, 3'h2);
      boot(3'h5, APPLY_TIMEOUT, APPLY_CONFIRM, START_RESTORE, 3'h1, 3'h0);
      for (int c = 1; c < 8; c++) begin
         i_src.set_code(3'(c));
         check(pend, (c > 5) ? 3'h5 : 3'(c));
         check(rng_al, c > 5);
         check(pos, 3'h1);
      end
      i_src.pulse(0);
      check(pend, 3'h5);
      check(notice, 1'b0);
      i_src.pulse(1);
      check(pos, 3'h1);
      i_src.set_code(3'h0);
      check(pend, 3'h5);
      i_src.set_code(3'h3);
      i_src.pulse(2);
      check(pos, 3'h3);
      check(ev_last, {1'b1, EV_POSITION, 3'h3});
      ev_en = 1'b0;
      tmo = 16'h0007;
      boot(3'h7, APPLY_CONFIRM, APPLY_TIMEOUT, START_RESTORE, 3'h7, 3'h0);
      i_src.pulse(0);
      check(pend, 3'h1);
      i_src.pulse(1);
      check(pos, 3'h1);
      check(store_cnt, 1);
      check(ev_last, 6'h00);
      final_report();
   end
endmodule : position_selector_switch_test
